/* File: hdl/dac_link_host.sv */
/*
  host end: axi4-lite slave that sends 24-bit frames on the serial link
  and captures the returned bits. assumes the device samples on falling sclk.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dac_link_host #(
  parameter int PU_WAIT = dac_pwr_pkg::PU_WAIT_CYC,
  parameter int HALF = dac_pwr_pkg::SCLK_HALF
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // axi4-lite slave
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial link
  dac_link_if.host link
);
  typedef enum logic [1:0] {IDLE = 2'b00, SHIFT = 2'b01, FINISH = 2'b10, PU_HOLD = 2'b11} st_e;
  st_e st_r, st_nxt;
  logic [3:0] aw_r, aw_nxt;
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ext_ref_r, ext_ref_nxt;
  logic [23:0] tx_r, tx_nxt, rx_r, rx_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] div_r, div_nxt;
  logic [15:0] wait_r, wait_nxt;
  logic pu_set_r, pu_set_nxt;
  logic sclk_r, sclk_nxt, sync_n_r, sync_n_nxt, sdin_r, sdin_nxt;
  logic tick;
  logic [23:0] frame;

  always_comb begin
    st_nxt = st_r;
    aw_nxt = aw_r;
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt = w_ok_r;
    wd_nxt = wd_r;
    bvalid_nxt = bvalid_r & ~bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r & ~rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ext_ref_nxt = ext_ref_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    cnt_nxt = cnt_r;
    pu_set_nxt = pu_set_r;
    wait_nxt = wait_r;
    sclk_nxt = sclk_r;
    sync_n_nxt = sync_n_r;
    sdin_nxt = sdin_r;
    tick = (div_r == 8'(HALF - 1));
    div_nxt = (tick || st_r == IDLE) ? 8'h00 : div_r + 8'h01;
    frame = wd_r[23:0];
    // external reference: the reference bit never leaves the host set
    if (ext_ref_r && frame[dac_pwr_pkg::REG_HI:dac_pwr_pkg::REG_LO] == dac_pwr_pkg::REG_POWER) begin
      frame[dac_pwr_pkg::VREF_POWER_ON_BIT] = 1'b0;
    end
    frame[dac_pwr_pkg::ZERO_BIT] = (frame[dac_pwr_pkg::REG_HI:dac_pwr_pkg::REG_LO] == dac_pwr_pkg::REG_POWER)
      ? 1'b0 : frame[dac_pwr_pkg::ZERO_BIT];
    if (awvalid && awready_r) begin
      aw_nxt = awaddr;
      aw_ok_nxt = 1'b1;
    end
    if (wvalid && wready_r) begin
      wd_nxt = wdata;
      w_ok_nxt = 1'b1;
    end
    if (aw_ok_r && w_ok_r && !bvalid_r) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = 2'b00;
      if (aw_r == dac_pwr_pkg::AXI_FRAME) begin
        // a frame written while busy is dropped
        if (st_r == IDLE && wstrb != 4'h0) begin
          st_nxt = SHIFT;
          sync_n_nxt = 1'b0;
          sdin_nxt = frame[23];
          tx_nxt = {frame[22:0], 1'b0};
          cnt_nxt = 5'h00;
          pu_set_nxt = frame[dac_pwr_pkg::REG_HI:dac_pwr_pkg::REG_LO] == dac_pwr_pkg::REG_POWER
            && !frame[dac_pwr_pkg::RW_BIT] && (frame[dac_pwr_pkg::PU_A_BIT] || frame[dac_pwr_pkg::PU_B_BIT]);
        end
      end else if (aw_r == dac_pwr_pkg::AXI_CFG) begin
        ext_ref_nxt = wd_r[0];
      end else if (aw_r != dac_pwr_pkg::AXI_STATUS && aw_r != dac_pwr_pkg::AXI_RX) begin
        bresp_nxt = 2'b10;
      end
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'b00;
      unique case (araddr)
        dac_pwr_pkg::AXI_FRAME: rdata_nxt = {8'h00, wd_r[23:0]};
        dac_pwr_pkg::AXI_STATUS: rdata_nxt = {30'h00000000, st_r == PU_HOLD, st_r != IDLE};
        dac_pwr_pkg::AXI_RX: rdata_nxt = {8'h00, rx_r};
        dac_pwr_pkg::AXI_CFG: rdata_nxt = {31'h00000000, ext_ref_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = 2'b10;
        end
      endcase
    end
    // sclk idles high; device takes sdin on the fall, we take sdo there too
    unique case (st_r)
      IDLE: begin
      end
      SHIFT: begin
        if (tick) begin
          if (sclk_r) begin
            sclk_nxt = 1'b0;
            rx_nxt = {rx_r[22:0], link.sdo};
          end else begin
            sclk_nxt = 1'b1;
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(dac_pwr_pkg::FRAME_W - 1)) begin
              st_nxt = FINISH;
            end else begin
              sdin_nxt = tx_r[23];
              tx_nxt = {tx_r[22:0], 1'b0};
            end
          end
        end
      end
      FINISH: begin
        if (tick) begin
          sync_n_nxt = 1'b1;
          wait_nxt = 16'(PU_WAIT);
          st_nxt = pu_set_r ? PU_HOLD : IDLE;
        end
      end
      PU_HOLD: begin
        // channel settling time before its output may be loaded
        wait_nxt = wait_r - 16'h0001;
        if (wait_r <= 16'h0001) begin
          st_nxt = IDLE;
        end
      end
    endcase
    awready_nxt = ~aw_ok_nxt & ~bvalid_nxt;
    wready_nxt = ~w_ok_nxt & ~bvalid_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= IDLE;
      aw_r <= 4'h0;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      wd_r <= 32'h00000000;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rresp_r <= 2'b00;
      rdata_r <= 32'h00000000;
      ext_ref_r <= 1'b0;
      tx_r <= 24'h000000;
      rx_r <= 24'h000000;
      cnt_r <= 5'h00;
      div_r <= 8'h00;
      wait_r <= 16'h0000;
      pu_set_r <= 1'b0;
      sclk_r <= 1'b1;
      sync_n_r <= 1'b1;
      sdin_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      aw_r <= aw_nxt;
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      wd_r <= wd_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ext_ref_r <= ext_ref_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      wait_r <= wait_nxt;
      pu_set_r <= pu_set_nxt;
      sclk_r <= sclk_nxt;
      sync_n_r <= sync_n_nxt;
      sdin_r <= sdin_nxt;
    end
  end

  always_comb begin
    awready = awready_r;
    wready = wready_r;
    arready = arready_r;
    bvalid = bvalid_r;
    bresp = bresp_r;
    rvalid = rvalid_r;
    rresp = rresp_r;
    rdata = rdata_r;
    link.sclk = sclk_r;
    link.sync_n = sync_n_r;
    link.sdin = sdin_r;
  end
endmodule
`default_nettype wire

/* File: hdl/dac_link_if.sv */
/*
  serial link between the controller and the dac power/fault logic.
  assumes both ends share one clock; sclk is an ordinary sampled signal.
*/
`timescale 1ns/100ps
`default_nettype none
interface dac_link_if;
  logic sclk;
  logic sync_n;
  logic sdin;
  logic sdo;
  modport device (input sclk, input sync_n, input sdin, output sdo);
  modport host (output sclk, output sync_n, output sdin, input sdo);
endinterface
`default_nettype wire

/* File: hdl/dac_power_fault_control.sv */
/*
  device end: frame receiver, power/fault control word, control bits,
  output hold and clear logic. assumes detectors are levels synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dac_power_fault_control #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial link
  dac_link_if.device link,
  // analog detectors and status
  input wire logic [1:0] overcurrent_det,
  input wire logic overtemp_det,
  input wire logic supplies_ok,
  input wire logic [1:0] range_bipolar,
  // power and output control
  output logic [1:0] chan_power_on,
  output logic vref_power_on,
  output logic [1:0] amp_connect,
  output logic output_hold,
  output logic clear_pulse,
  output logic [3:0] clear_code,
  output logic [1:0] chan_overcurrent,
  output logic overtemp_alert
);
  logic sclk_q_r, sclk_q_nxt;
  logic sync_q_r, sync_q_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic [23:0] rb_r, rb_nxt;
  logic sdo_r, sdo_nxt;
  logic [1:0] pu_r, pu_nxt;
  logic vref_power_on_r, vref_power_on_nxt;
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [1:0] oc_r, oc_nxt;
  logic tsd_r, tsd_nxt;
  logic hold_r, hold_nxt;
  logic written_r, written_nxt;
  logic [1:0] amp_r, amp_nxt;
  logic clr_r, clr_nxt;
  logic [3:0] code_r, code_nxt;
  logic fall, rise, frame_end;
  logic [2:0] f_reg, f_adr;
  logic [15:0] power_word;
  logic [1:0] fault_off;
  logic overheat;

  always_comb begin
    fall = sclk_q_r & ~link.sclk & ~link.sync_n;
    rise = ~sclk_q_r & link.sclk & ~link.sync_n;
    frame_end = ~sync_q_r & link.sync_n & (cnt_r == 5'(dac_pwr_pkg::FRAME_W));
    f_reg = sh_r[dac_pwr_pkg::REG_HI:dac_pwr_pkg::REG_LO];
    f_adr = sh_r[dac_pwr_pkg::ADR_HI:dac_pwr_pkg::ADR_LO];
    power_word = 16'h0000;
    power_word[dac_pwr_pkg::PU_A_BIT] = pu_r[0];
    power_word[dac_pwr_pkg::PU_B_BIT] = pu_r[1];
    power_word[dac_pwr_pkg::VREF_POWER_ON_BIT] = vref_power_on_r;
    power_word[dac_pwr_pkg::TSD_BIT] = tsd_r;
    power_word[dac_pwr_pkg::OC_A_BIT] = oc_r[0];
    power_word[dac_pwr_pkg::OC_B_BIT] = oc_r[1];
  end

  // frame receiver: bits taken on falling sclk, readback shifted on rising
  always_comb begin
    sclk_q_nxt = link.sclk;
    sync_q_nxt = link.sync_n;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rb_nxt = rb_r;
    sdo_nxt = sdo_r;
    if (sync_q_r & ~link.sync_n) begin
      cnt_nxt = 5'h00;
      sdo_nxt = rb_r[23] & ~ctrl_r[dac_pwr_pkg::SDO_DIS_BIT];
    end
    if (fall && cnt_r != 5'(dac_pwr_pkg::FRAME_W)) begin
      sh_nxt = {sh_r[22:0], link.sdin};
      cnt_nxt = cnt_r + 5'h01;
    end
    if (rise) begin
      rb_nxt = {rb_r[22:0], 1'b0};
      sdo_nxt = rb_r[22] & ~ctrl_r[dac_pwr_pkg::SDO_DIS_BIT];
    end
    if (link.sync_n) begin
      sdo_nxt = 1'b0;
    end
    // a read frame queues the selected word for the next frame
    if (frame_end) begin
      rb_nxt = 24'h000000;
      if (sh_r[dac_pwr_pkg::RW_BIT]) begin
        rb_nxt[23:16] = sh_r[23:16];
        if (f_reg == dac_pwr_pkg::REG_POWER) begin
          rb_nxt[15:0] = power_word;
        end else if (f_reg == dac_pwr_pkg::REG_CTRL) begin
          rb_nxt[3:0] = ctrl_r;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_q_r <= 1'b1;
      sync_q_r <= 1'b1;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
      rb_r <= 24'h000000;
      sdo_r <= 1'b0;
    end else begin
      sclk_q_r <= sclk_q_nxt;
      sync_q_r <= sync_q_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rb_r <= rb_nxt;
      sdo_r <= sdo_nxt;
    end
  end

  assign link.sdo = sdo_r;

  // control state: power bits, control bits, alerts, hold and clear
  always_comb begin
    pu_nxt = pu_r;
    vref_power_on_nxt = vref_power_on_r;
    ctrl_nxt = ctrl_r;
    written_nxt = written_r;
    hold_nxt = hold_r;
    clr_nxt = 1'b0;
    code_nxt = code_r;
    overheat = overtemp_det & ctrl_r[dac_pwr_pkg::TSD_EN_BIT];
    if (frame_end && !sh_r[dac_pwr_pkg::RW_BIT]) begin
      if (f_reg == dac_pwr_pkg::REG_DAC) begin
        written_nxt = 1'b1;
      end
      // alert positions in the power word are dropped here
      if (f_reg == dac_pwr_pkg::REG_POWER && f_adr == dac_pwr_pkg::ADR_POWER) begin
        pu_nxt[0] = sh_r[dac_pwr_pkg::PU_A_BIT];
        pu_nxt[1] = sh_r[dac_pwr_pkg::PU_B_BIT];
        vref_power_on_nxt = sh_r[dac_pwr_pkg::VREF_POWER_ON_BIT];
      end
      if (f_reg == dac_pwr_pkg::REG_CTRL && f_adr == dac_pwr_pkg::ADR_CTRL_SET) begin
        ctrl_nxt = sh_r[3:0];
      end
      if (f_reg == dac_pwr_pkg::REG_CTRL && f_adr == dac_pwr_pkg::ADR_CLEAR) begin
        clr_nxt = 1'b1;
        for (int i = 0; i < CHANNELS; i++) begin
          if (!ctrl_r[dac_pwr_pkg::CLR_SEL_BIT]) begin
            code_nxt[2*i +: 2] = dac_pwr_pkg::CLR_ZERO;
          end else if (range_bipolar[i]) begin
            code_nxt[2*i +: 2] = dac_pwr_pkg::CLR_NEG_FULL;
          end else begin
            code_nxt[2*i +: 2] = dac_pwr_pkg::CLR_MID;
          end
        end
      end
    end
    // fault shutdown is applied after the host write so it always wins
    for (int i = 0; i < CHANNELS; i++) begin
      fault_off[i] = overheat | (overcurrent_det[i] & ~ctrl_r[dac_pwr_pkg::CLAMP_BIT]);
    end
    pu_nxt = pu_nxt & ~fault_off;
    oc_nxt = overcurrent_det;
    tsd_nxt = overheat;
    // hold releases once supplies settle and a dac word has arrived
    if (supplies_ok && written_r) begin
      hold_nxt = 1'b0;
    end
    for (int i = 0; i < CHANNELS; i++) begin
      amp_nxt[i] = pu_r[i] & ~hold_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pu_r <= 2'h0;
      vref_power_on_r <= 1'b0;
      ctrl_r <= dac_pwr_pkg::CTRL_RST;
      oc_r <= 2'h0;
      tsd_r <= 1'b0;
      hold_r <= 1'b1;
      written_r <= 1'b0;
      amp_r <= 2'h0;
      clr_r <= 1'b0;
      code_r <= 4'h0;
    end else begin
      pu_r <= pu_nxt;
      vref_power_on_r <= vref_power_on_nxt;
      ctrl_r <= ctrl_nxt;
      oc_r <= oc_nxt;
      tsd_r <= tsd_nxt;
      hold_r <= hold_nxt;
      written_r <= written_nxt;
      amp_r <= amp_nxt;
      clr_r <= clr_nxt;
      code_r <= code_nxt;
    end
  end

  always_comb begin
    chan_power_on = pu_r;
    vref_power_on = vref_power_on_r;
    amp_connect = amp_r;
    output_hold = hold_r;
    clear_pulse = clr_r;
    clear_code = code_r;
    chan_overcurrent = oc_r;
    overtemp_alert = tsd_r;
  end
endmodule
`default_nettype wire

/* File: hdl/dac_pwr_pkg.sv */
/*
  constants shared by both ends of the serial power and fault control link.
  assumes a 20 mhz clock and 24-bit frames, msb first, sampled on falling sclk.
*/
package dac_pwr_pkg;
  localparam int FRAME_W = 24;
  localparam int RW_BIT = 23;
  localparam int REG_HI = 21;
  localparam int REG_LO = 19;
  localparam int ADR_HI = 18;
  localparam int ADR_LO = 16;
  localparam logic [2:0] REG_DAC = 3'h0;
  localparam logic [2:0] REG_POWER = 3'h2;
  localparam logic [2:0] REG_CTRL = 3'h3;
  localparam logic [2:0] ADR_POWER = 3'h0;
  localparam logic [2:0] ADR_CTRL_SET = 3'h1;
  localparam logic [2:0] ADR_CLEAR = 3'h4;
  localparam int PU_A_BIT = 0;
  localparam int PU_B_BIT = 2;
  localparam int VREF_POWER_ON_BIT = 4;
  localparam int TSD_BIT = 5;
  localparam int ZERO_BIT = 6;
  localparam int OC_A_BIT = 7;
  localparam int OC_B_BIT = 9;
  localparam int SDO_DIS_BIT = 0;
  localparam int CLR_SEL_BIT = 1;
  localparam int CLAMP_BIT = 2;
  localparam int TSD_EN_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h4;
  localparam logic [2:0] POWER_RST = 3'h0;
  localparam logic [1:0] CLR_ZERO = 2'h0;
  localparam logic [1:0] CLR_MID = 2'h1;
  localparam logic [1:0] CLR_NEG_FULL = 2'h2;
  localparam int CLK_NS = 50;
  localparam int PU_WAIT_NS = 10000;
  localparam int PU_WAIT_CYC = (PU_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF = 4;
  localparam logic [3:0] AXI_FRAME = 4'h0;
  localparam logic [3:0] AXI_STATUS = 4'h4;
  localparam logic [3:0] AXI_RX = 4'h8;
  localparam logic [3:0] AXI_CFG = 4'hc;
endpackage

/* File: verif/dac_pwr_checker.sv */
/*
  concurrent checks on the serial link and the device power outputs.
  assumes one clock domain; instantiated in tb beside the link interface.
*/
`timescale 1ns/100ps
`default_nettype none
module dac_pwr_checker (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial link
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic sdo,
  // device side
  input wire logic [1:0] overcurrent_det,
  input wire logic overtemp_det,
  input wire logic [1:0] chan_power_on,
  input wire logic vref_power_on,
  input wire logic [1:0] amp_connect,
  input wire logic output_hold,
  input wire logic [1:0] chan_overcurrent,
  input wire logic overtemp_alert
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_sclk_idle_high: assert property (sync_n |-> sclk)
    else $error("sclk low outside a frame");
  // sdo is registered, so one cycle of grace after the frame ends
  a_sdo_quiet_idle: assert property (sync_n && $past(sync_n) |-> !sdo)
    else $error("sdo driven outside a frame");
  a_sdin_held: assert property (!sync_n && !$past(sync_n) && $stable(sclk) |-> $stable(sdin))
    else $error("sdin changed away from a rising sclk");
  a_reset_powered_down: assert property ($fell(srst) |-> chan_power_on == 2'h0 && !vref_power_on)
    else $error("power bits not cleared by reset");
  a_reset_output_held: assert property ($fell(srst) |-> output_hold && amp_connect == 2'h0)
    else $error("outputs not held after reset");
  a_amp_needs_power: assert property (amp_connect[1] |-> $past(chan_power_on[1]) && !$past(output_hold))
    else $error("amplifier connected while down or held");
  a_oc_flag_rises: assert property ($rose(overcurrent_det[0]) |-> ##[1:3] chan_overcurrent[0])
    else $error("overcurrent flag did not follow detector");
  a_oc_flag_clears: assert property ($fell(overcurrent_det[1]) |-> ##[1:3] !chan_overcurrent[1])
    else $error("overcurrent flag did not clear");
  a_overtemp_down: assert property ($rose(overtemp_alert) |-> ##[0:1] chan_power_on == 2'h0)
    else $error("overtemperature left a channel powered");
  a_alert_has_cause: assert property (overtemp_alert |-> overtemp_det || $past(overtemp_det))
    else $error("thermal alert without detector");
  c_frame: cover property ($fell(sync_n));
  c_oc: cover property ($rose(chan_overcurrent[0]));
  c_thermal: cover property ($rose(overtemp_alert));
  c_amp: cover property ($rose(amp_connect[0]));
endmodule
`default_nettype wire

/* File: verif/tb.sv */
/*
  self-checking bench: axi4-lite master into the host end, device end on the link.
  assumes the host answers every request; a cycle ceiling cuts a hang.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [1:0] overcurrent_det = 2'h0, range_bipolar = 2'h0;
  logic overtemp_det = 1'b0, supplies_ok = 1'b0;
  logic [1:0] chan_power_on, amp_connect, chan_overcurrent;
  logic vref_power_on, output_hold, clear_pulse, overtemp_alert;
  logic [3:0] clear_code, seen_code = 4'hf;
  int errors = 0, samples_checked = 0, cycles = 0;
  dac_link_if link();
  dac_power_fault_control i_dac_power_fault_control (.clk(clk), .srst(srst), .link(link),
    .overcurrent_det(overcurrent_det), .overtemp_det(overtemp_det), .supplies_ok(supplies_ok),
    .range_bipolar(range_bipolar), .chan_power_on(chan_power_on), .vref_power_on(vref_power_on),
    .amp_connect(amp_connect), .output_hold(output_hold), .clear_pulse(clear_pulse),
    .clear_code(clear_code), .chan_overcurrent(chan_overcurrent), .overtemp_alert(overtemp_alert));
  // short power-up wait keeps the run brief
  dac_link_host #(.PU_WAIT(4)) i_dac_link_host (.clk(clk), .srst(srst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(link));
  dac_pwr_checker i_dac_pwr_checker (.clk(clk), .srst(srst), .sclk(link.sclk), .sync_n(link.sync_n),
    .sdin(link.sdin), .sdo(link.sdo), .overcurrent_det(overcurrent_det), .overtemp_det(overtemp_det),
    .chan_power_on(chan_power_on), .vref_power_on(vref_power_on), .amp_connect(amp_connect),
    .output_hold(output_hold), .chan_overcurrent(chan_overcurrent), .overtemp_alert(overtemp_alert));
  always #25 clk = ~clk;
  // clear_pulse stands one cycle, so its code is caught here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (clear_pulse) begin
      seen_code <= clear_code;
    end
    if (cycles == 60000) begin
      errors = errors + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready) begin
        awvalid <= 1'b0;
      end
      if (wready) begin
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  function automatic logic [31:0] frm(input logic rw, input logic [2:0] rs, input logic [2:0] ad,
    input logic [15:0] d);
    return {8'h00, rw, 1'b0, rs, ad, d};
  endfunction
  task automatic idle();
    logic [31:0] s;
    logic [1:0] r;
    s = 32'h1;
    while (s[0]) begin
      axi_read(dac_pwr_pkg::AXI_STATUS, s, r);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic send(input logic [31:0] f);
    logic [1:0] r;
    axi_write(dac_pwr_pkg::AXI_FRAME, f, r);
    idle();
  endtask
  task automatic rd(input logic [2:0] rs, input logic [2:0] ad, output logic [15:0] v);
    logic [31:0] x;
    logic [1:0] r;
    send(frm(1'b1, rs, ad, 16'h0000));
    send(frm(1'b0, dac_pwr_pkg::REG_CTRL, 3'h0, 16'h0000));
    axi_read(dac_pwr_pkg::AXI_RX, x, r);
    v = x[15:0];
  endtask
  task automatic t_reset();
    logic [15:0] v;
    logic [31:0] x;
    logic [1:0] r;
    check({28'h0, chan_power_on, vref_power_on, output_hold}, 32'h1);
    check({30'h0, amp_connect}, 32'h0);
    rd(dac_pwr_pkg::REG_POWER, dac_pwr_pkg::ADR_POWER, v);
    check({16'h0, v}, 32'h0);
    rd(dac_pwr_pkg::REG_CTRL, dac_pwr_pkg::ADR_CTRL_SET, v);
    check({16'h0, v}, 32'h4);
    // with sdo disabled the whole readback shifts in as zero
    send(frm(1'b0, dac_pwr_pkg::REG_CTRL, dac_pwr_pkg::ADR_CTRL_SET, 16'h0005));
    rd(dac_pwr_pkg::REG_CTRL, dac_pwr_pkg::ADR_CTRL_SET, v);
    check({16'h0, v}, 32'h0);
    send(frm(1'b0, dac_pwr_pkg::REG_CTRL, dac_pwr_pkg::ADR_CTRL_SET, 16'h0004));
    axi_read(4'h2, x, r);
    check({r, x[29:0]}, 32'h80000000);
    axi_write(4'h2, 32'h0, r);
    check({30'h0, r}, 32'h2);
  endtask
  task automatic t_power();
    logic [15:0] v;
    logic [1:0] r;
    logic [31:0] s;
    // alert, db6 and don't-care bits set on purpose; second frame lands while busy
    axi_write(dac_pwr_pkg::AXI_FRAME, frm(1'b0, dac_pwr_pkg::REG_POWER, 3'h0, 16'hfdf5), r);
    check({30'h0, r}, 32'h0);
    axi_read(dac_pwr_pkg::AXI_STATUS, s, r);
    check({31'h0, s[0]}, 32'h1);
    axi_write(dac_pwr_pkg::AXI_FRAME, frm(1'b0, dac_pwr_pkg::REG_POWER, 3'h0, 16'h0000), r);
    idle();
    check({27'h0, chan_power_on, vref_power_on, chan_overcurrent != 2'h0 || overtemp_alert}, 32'h0e);
    rd(dac_pwr_pkg::REG_POWER, dac_pwr_pkg::ADR_POWER, v);
    check({16'h0, v}, 32'h0015);
    axi_write(dac_pwr_pkg::AXI_CFG, 32'h1, r);
    send(frm(1'b0, dac_pwr_pkg::REG_POWER, 3'h0, 16'h0015));
    check({31'h0, vref_power_on}, 32'h0);
    axi_write(dac_pwr_pkg::AXI_CFG, 32'h0, r);
  endtask
  task automatic t_clamp_on();
    logic [15:0] v;
    @(posedge clk) overcurrent_det <= 2'b10;
    repeat (4) @(posedge clk);
    check({28'h0, chan_overcurrent, chan_power_on}, 32'hb);
    rd(dac_pwr_pkg::REG_POWER, dac_pwr_pkg::ADR_POWER, v);
    check({16'h0, v}, 32'h0205);
    @(posedge clk) overcurrent_det <= 2'b00;
    repeat (4) @(posedge clk);
    check({30'h0, chan_overcurrent}, 32'h0);
  endtask
  task automatic t_clamp_off();
    logic [15:0] v;
    send(frm(1'b0, dac_pwr_pkg::REG_CTRL, dac_pwr_pkg::ADR_CTRL_SET, 16'h0000));
    @(posedge clk) overcurrent_det <= 2'b01;
    repeat (4) @(posedge clk);
    check({28'h0, chan_overcurrent, chan_power_on}, 32'h6);
    rd(dac_pwr_pkg::REG_POWER, dac_pwr_pkg::ADR_POWER, v);
    check({16'h0, v}, 32'h0084);
    @(posedge clk) overcurrent_det <= 2'b00;
    send(frm(1'b0, dac_pwr_pkg::REG_POWER, 3'h0, 16'h0015));
    check({30'h0, chan_power_on}, 32'h3);
  endtask
  task automatic t_thermal();
    logic [15:0] v;
    @(posedge clk) overtemp_det <= 1'b1;
    repeat (4) @(posedge clk);
    check({29'h0, overtemp_alert, chan_power_on}, 32'h3);
    send(frm(1'b0, dac_pwr_pkg::REG_CTRL, dac_pwr_pkg::ADR_CTRL_SET, 16'h0008));
    check({29'h0, overtemp_alert, chan_power_on}, 32'h4);
    rd(dac_pwr_pkg::REG_POWER, dac_pwr_pkg::ADR_POWER, v);
    check({16'h0, v}, 32'h0030);
    @(posedge clk) overtemp_det <= 1'b0;
    repeat (4) @(posedge clk);
    check({31'h0, overtemp_alert}, 32'h0);
  endtask
  task automatic t_hold();
    logic [31:0] s;
    logic [1:0] r;
    logic seen_wait;
    seen_wait = 1'b0;
    axi_write(dac_pwr_pkg::AXI_FRAME, frm(1'b0, dac_pwr_pkg::REG_POWER, 3'h0, 16'h0015), r);
    // status is polled every third cycle, so the short wait is always caught
    s = 32'h1;
    while (s[0]) begin
      axi_read(dac_pwr_pkg::AXI_STATUS, s, r);
      seen_wait = seen_wait | s[1];
    end
    check({31'h0, seen_wait}, 32'h1);
    send(frm(1'b0, dac_pwr_pkg::REG_DAC, 3'h0, 16'h1234));
    check({29'h0, output_hold, amp_connect}, 32'h4);
    @(posedge clk) supplies_ok <= 1'b1;
    send(frm(1'b0, dac_pwr_pkg::REG_DAC, 3'h0, 16'h1234));
    check({29'h0, output_hold, amp_connect}, 32'h3);
    send(frm(1'b0, dac_pwr_pkg::REG_POWER, 3'h0, 16'h0001));
    check({30'h0, amp_connect}, 32'h1);
  endtask
  task automatic t_clear();
    logic [1:0] a, b;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) range_bipolar <= i[1] ? 2'b10 : 2'b01;
      a = i[0] ? (i[1] ? dac_pwr_pkg::CLR_MID : dac_pwr_pkg::CLR_NEG_FULL) : dac_pwr_pkg::CLR_ZERO;
      b = i[0] ? (i[1] ? dac_pwr_pkg::CLR_NEG_FULL : dac_pwr_pkg::CLR_MID) : dac_pwr_pkg::CLR_ZERO;
      send(frm(1'b0, dac_pwr_pkg::REG_CTRL, dac_pwr_pkg::ADR_CTRL_SET, {14'h0001, i[0], 1'b0}));
      send(frm(1'b0, dac_pwr_pkg::REG_CTRL, dac_pwr_pkg::ADR_CLEAR, 16'h0000));
      check({28'h0, seen_code}, {28'h0, b, a});
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_power();
    t_clamp_on();
    t_clamp_off();
    t_thermal();
    t_hold();
    t_clear();
    wrap_up();
  end
endmodule
`default_nettype wire
